//--- clpcg_pkg.sv
// package: constants and types for the core low-power clock gating block
package clpcg_pkg;

  // ----------------------------------------------------------------
  // power-mode request codes from the power policy controller
  // ----------------------------------------------------------------
  localparam int unsigned CLPCG_MODE_W = 3;
  localparam logic [2:0] CLPCG_MODE_ON = 3'h0;
  localparam logic [2:0] CLPCG_MODE_FULL_RET = 3'h1;
  localparam logic [2:0] CLPCG_MODE_OFF = 3'h2;
  localparam logic [2:0] CLPCG_MODE_OFF_EMU = 3'h3;
  localparam logic [2:0] CLPCG_MODE_DBG_RECOV = 3'h4;
  localparam logic [2:0] CLPCG_MODE_WARM_RST = 3'h5;

  // ----------------------------------------------------------------
  // state widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CLPCG_KEEP_W = 8;
  localparam logic [7:0] CLPCG_KEEP_RST = 8'h00;
  localparam logic [2:0] CLPCG_MODE_RST = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLPCG_CLK_NS = 20;
  // time in ns the gate stays open after the last service request, turned into a cycle count below
  localparam int unsigned CLPCG_SERVICE_HOLD_NS = 40;
  localparam int unsigned CLPCG_SERVICE_HOLD_CYC =
    (CLPCG_SERVICE_HOLD_NS / CLPCG_CLK_NS) < 1 ? 1 : (CLPCG_SERVICE_HOLD_NS / CLPCG_CLK_NS);
  localparam logic [3:0] CLPCG_HOLD_LOAD = 4'(CLPCG_SERVICE_HOLD_CYC);

  // ----------------------------------------------------------------
  // wait-state controller and power-mode handshake states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLPCG_RUN,
    CLPCG_DRAIN,
    CLPCG_SLEEP,
    CLPCG_SERVICE,
    CLPCG_WAKE
  } clpcg_state_type;

  typedef enum logic [1:0] {
    CLPCG_PM_IDLE,
    CLPCG_PM_PREP,
    CLPCG_PM_ACCEPT
  } clpcg_pm_type;

endpackage : clpcg_pkg

//--- clpcg_clock_gate.sv
// module: glitch-free clock gate with latched enable
`timescale 1ns/1ps
`default_nettype none
module clpcg_clock_gate (
  input wire logic clk_in,
  input wire logic enable,
  output logic clk_out
);
  logic en_latch;

  // latch transparent while the clock is low, so enable cannot chop a high phase
  always_latch begin
    if (!clk_in) begin
      en_latch <= enable;
    end
  end

  assign clk_out = clk_in & en_latch;
endmodule : clpcg_clock_gate
`default_nettype wire

//--- clpcg_core.sv
// module: core wait-state clock gating, reset scoping and power-mode handshake
`timescale 1ns/1ps
`default_nettype none
module clpcg_core
  import clpcg_pkg::*;
#(
  parameter int unsigned KEEP_W = CLPCG_KEEP_W
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WARM_RST,
  input wire logic WAIT_INT_REQ,
  input wire logic WAIT_EVT_REQ,
  input wire logic SEND_EVENT,
  input wire logic INFLIGHT_BUSY,
  input wire logic STORE_PENDING,
  input wire logic PHYS_IRQ,
  input wire logic VIRT_IRQ,
  input wire logic WAKE_EVENT,
  input wire logic SNOOP_REQ,
  input wire logic MAINT_REQ,
  input wire logic UTIL_BUS_REQ,
  input wire logic INTC_ACCESS_REQ,
  input wire logic DEBUG_APB_REQ,
  input wire logic SERVICE_BUSY,
  input wire logic PM_REQ,
  input wire logic [CLPCG_MODE_W-1:0] PM_MODE,
  input wire logic CACHE_CLEAN_DONE,
  input wire logic COHERENCY_OFF_DONE,
  input wire logic [KEEP_W-1:0] KEEP_DATA_IN,
  input wire logic KEEP_DATA_WE,
  input wire logic [KEEP_W-1:0] FUNC_DATA_IN,
  input wire logic FUNC_DATA_WE,
  output logic GATED_CLK,
  output logic CLK_ENABLE,
  output logic IN_WAIT,
  output logic WAIT_IS_EVENT,
  output logic CLK_TEMP_ON,
  output logic EVENT_FLAG,
  output logic WAKE_PULSE,
  output logic PM_ACCEPT,
  output logic [CLPCG_MODE_W-1:0] PM_MODE_NOW,
  output logic CACHE_CLEAN_REQ,
  output logic COHERENCY_OFF_REQ,
  output logic [KEEP_W-1:0] KEEP_DATA,
  output logic [KEEP_W-1:0] FUNC_DATA
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic service_pending(input logic snp, input logic mnt, input logic utl,
                                           input logic intc, input logic dbg);
    service_pending = snp | mnt | utl | intc | dbg;
  endfunction : service_pending

  function automatic logic mode_needs_sleep(input logic [CLPCG_MODE_W-1:0] m);
    mode_needs_sleep = (m == CLPCG_MODE_FULL_RET) | (m == CLPCG_MODE_OFF);
  endfunction : mode_needs_sleep

  clpcg_state_type state_reg;
  clpcg_state_type state_next;
  clpcg_pm_type pm_reg;
  clpcg_pm_type pm_next;
  logic [3:0] hold_reg;
  logic wait_evt_reg;
  logic event_reg;
  logic wake_reg;
  logic clk_en;
  logic svc_req;
  logic wakeup;
  logic any_rst;
  logic drained;
  logic prep_ok;

  assign any_rst = RST | WARM_RST;
  assign svc_req = service_pending(SNOOP_REQ, MAINT_REQ, UTIL_BUS_REQ,
                                   INTC_ACCESS_REQ, DEBUG_APB_REQ);
  assign wakeup = PHYS_IRQ | VIRT_IRQ | WAKE_EVENT | (wait_evt_reg & SEND_EVENT);
  assign drained = !INFLIGHT_BUSY && !STORE_PENDING;

  // ----------------------------------------------------------------
  // wait-state controller
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CLPCG_RUN: begin
        if (WAIT_EVT_REQ && event_reg) begin
          state_next = CLPCG_RUN;
        end else if (WAIT_INT_REQ || WAIT_EVT_REQ) begin
          state_next = CLPCG_DRAIN;
        end
      end
      CLPCG_DRAIN: begin
        if (wakeup) begin
          state_next = CLPCG_WAKE;
        end else if (drained) begin
          state_next = CLPCG_SLEEP;
        end
      end
      CLPCG_SLEEP: begin
        if (wakeup) begin
          state_next = CLPCG_WAKE;
        end else if (svc_req) begin
          state_next = CLPCG_SERVICE;
        end
      end
      CLPCG_SERVICE: begin
        if (wakeup) begin
          state_next = CLPCG_WAKE;
        end else if (!svc_req && !SERVICE_BUSY && hold_reg == 4'h0) begin
          state_next = CLPCG_SLEEP;
        end
      end
      CLPCG_WAKE: begin
        state_next = CLPCG_RUN;
      end
    endcase
  end

  // reset exits any wait state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= CLPCG_RUN;
    end else if (WARM_RST) begin
      state_reg <= CLPCG_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // keeps the gate open a little past the last request so back-to-back accesses do not thrash it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hold_reg <= 4'h0;
    end else if (WARM_RST) begin
      hold_reg <= 4'h0;
    end else if (svc_req || SERVICE_BUSY) begin
      hold_reg <= CLPCG_HOLD_LOAD;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wait_evt_reg <= 1'b0;
    end else if (WARM_RST) begin
      wait_evt_reg <= 1'b0;
    end else if (state_reg == CLPCG_RUN && state_next == CLPCG_DRAIN) begin
      wait_evt_reg <= WAIT_EVT_REQ && !WAIT_INT_REQ;
    end
  end

  // event flag: a send in the same cycle as the consuming wait keeps it set
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      event_reg <= 1'b0;
    end else if (WARM_RST) begin
      event_reg <= 1'b0;
    end else if (SEND_EVENT && state_reg == CLPCG_RUN) begin
      event_reg <= 1'b1;
    end else if (state_reg == CLPCG_RUN && WAIT_EVT_REQ && event_reg) begin
      event_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= (state_next == CLPCG_WAKE);
    end
  end

  // ----------------------------------------------------------------
  // power-mode handshake with the power policy controller
  // ----------------------------------------------------------------
  // the controller owns every decision; this side only prepares and accepts
  assign prep_ok = !mode_needs_sleep(PM_MODE) ||
                   ((state_reg == CLPCG_SLEEP) &&
                    (PM_MODE != CLPCG_MODE_OFF || (CACHE_CLEAN_DONE && COHERENCY_OFF_DONE)));

  always_comb begin
    pm_next = pm_reg;
    unique case (pm_reg)
      CLPCG_PM_IDLE: begin
        if (PM_REQ) begin
          pm_next = CLPCG_PM_PREP;
        end
      end
      CLPCG_PM_PREP: begin
        if (!PM_REQ) begin
          pm_next = CLPCG_PM_IDLE;
        end else if (prep_ok) begin
          pm_next = CLPCG_PM_ACCEPT;
        end
      end
      CLPCG_PM_ACCEPT: begin
        if (!PM_REQ) begin
          pm_next = CLPCG_PM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pm_reg <= CLPCG_PM_IDLE;
    end else if (WARM_RST) begin
      pm_reg <= CLPCG_PM_IDLE;
    end else begin
      pm_reg <= pm_next;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PM_MODE_NOW <= CLPCG_MODE_RST;
    end else if (pm_reg == CLPCG_PM_PREP && pm_next == CLPCG_PM_ACCEPT) begin
      PM_MODE_NOW <= PM_MODE;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CACHE_CLEAN_REQ <= 1'b0;
      COHERENCY_OFF_REQ <= 1'b0;
    end else begin
      CACHE_CLEAN_REQ <= (pm_next == CLPCG_PM_PREP) && (PM_MODE == CLPCG_MODE_OFF) && !CACHE_CLEAN_DONE;
      COHERENCY_OFF_REQ <= (pm_next == CLPCG_PM_PREP) && (PM_MODE == CLPCG_MODE_OFF) && !COHERENCY_OFF_DONE;
    end
  end

  // ----------------------------------------------------------------
  // reset scopes
  // ----------------------------------------------------------------
  // preserved storage: only a cold reset clears it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      KEEP_DATA <= KEEP_W'(CLPCG_KEEP_RST);
    end else if (KEEP_DATA_WE) begin
      KEEP_DATA <= KEEP_DATA_IN;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      FUNC_DATA <= KEEP_W'(CLPCG_KEEP_RST);
    end else if (WARM_RST) begin
      FUNC_DATA <= KEEP_W'(CLPCG_KEEP_RST);
    end else if (FUNC_DATA_WE) begin
      FUNC_DATA <= FUNC_DATA_IN;
    end
  end

  // ----------------------------------------------------------------
  // architectural clock gate
  // ----------------------------------------------------------------
  // combinational so a service request opens the gate in the same cycle it arrives
  assign clk_en = (state_reg != CLPCG_SLEEP) || svc_req || any_rst || wakeup;

  // the gate sits in the bridge side of the one clock input; core state is never lost while it is shut
  clpcg_clock_gate u_bridge_gate (
    .clk_in(SYS_CLK),
    .enable(clk_en),
    .clk_out(GATED_CLK)
  );

  assign CLK_ENABLE = clk_en;
  assign IN_WAIT = (state_reg == CLPCG_SLEEP) || (state_reg == CLPCG_SERVICE);
  assign WAIT_IS_EVENT = wait_evt_reg;
  assign CLK_TEMP_ON = (state_reg == CLPCG_SERVICE);
  assign EVENT_FLAG = event_reg;
  assign WAKE_PULSE = wake_reg;
  assign PM_ACCEPT = (pm_reg == CLPCG_PM_ACCEPT);

endmodule : clpcg_core
`default_nettype wire

//--- clpcg_core_chk.sv
// checker: timing relations of the core low-power clock gating block
`timescale 1ns/1ps
`default_nettype none
module clpcg_core_chk
  import clpcg_pkg::*;
#(
  parameter int unsigned KEEP_W = CLPCG_KEEP_W
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WARM_RST,
  input wire logic WAIT_INT_REQ,
  input wire logic WAIT_EVT_REQ,
  input wire logic SEND_EVENT,
  input wire logic INFLIGHT_BUSY,
  input wire logic STORE_PENDING,
  input wire logic PHYS_IRQ,
  input wire logic VIRT_IRQ,
  input wire logic WAKE_EVENT,
  input wire logic SNOOP_REQ,
  input wire logic MAINT_REQ,
  input wire logic UTIL_BUS_REQ,
  input wire logic INTC_ACCESS_REQ,
  input wire logic DEBUG_APB_REQ,
  input wire logic SERVICE_BUSY,
  input wire logic PM_REQ,
  input wire logic [CLPCG_MODE_W-1:0] PM_MODE,
  input wire logic CACHE_CLEAN_DONE,
  input wire logic COHERENCY_OFF_DONE,
  input wire logic KEEP_DATA_WE,
  input wire logic CLK_ENABLE,
  input wire logic IN_WAIT,
  input wire logic CLK_TEMP_ON,
  input wire logic EVENT_FLAG,
  input wire logic WAKE_PULSE,
  input wire logic PM_ACCEPT,
  input wire logic [CLPCG_MODE_W-1:0] PM_MODE_NOW,
  input wire logic [KEEP_W-1:0] KEEP_DATA,
  input wire logic [KEEP_W-1:0] FUNC_DATA
);
  wire logic req_any = SNOOP_REQ | MAINT_REQ | UTIL_BUS_REQ | INTC_ACCESS_REQ | DEBUG_APB_REQ;
  wire logic wake_any = PHYS_IRQ | VIRT_IRQ | WAKE_EVENT | SEND_EVENT;
  default clocking @(posedge SYS_CLK); endclocking
  // warm reset restarts the controller, so most relations pause under it
  default disable iff (RST || WARM_RST);
  drain_first_a: assert property ($rose(IN_WAIT) |-> $past(!INFLIGHT_BUSY && !STORE_PENDING))
    else $error("wait entered before drain");
  gated_wait_a: assert property (IN_WAIT && !CLK_TEMP_ON && !req_any && !wake_any |-> !CLK_ENABLE)
    else $error("clock running in idle wait");
  service_on_a: assert property (IN_WAIT && !CLK_TEMP_ON && req_any && !wake_any |->
    CLK_ENABLE ##1 (CLK_TEMP_ON && IN_WAIT))
    else $error("service did not reopen clock");
  service_end_a: assert property (not (CLK_TEMP_ON && !req_any && !SERVICE_BUSY && !wake_any) [*5])
    else $error("temporary clock not closed");
  regate_stay_a: assert property ($fell(CLK_TEMP_ON) && $past(!wake_any && !WARM_RST) |-> IN_WAIT)
    else $error("left wait after service");
  wake_exit_a: assert property (IN_WAIT && !CLK_TEMP_ON && (PHYS_IRQ || VIRT_IRQ || WAKE_EVENT) |->
    CLK_ENABLE ##1 !IN_WAIT ##[0:1] WAKE_PULSE)
    else $error("wakeup not honoured");
  event_skip_a: assert property (EVENT_FLAG && WAIT_EVT_REQ && !WAIT_INT_REQ && !SEND_EVENT && !IN_WAIT |=>
    (!EVENT_FLAG && !IN_WAIT) ##1 !IN_WAIT)
    else $error("event-wait with flag set misbehaved");
  warm_scope_a: assert property (disable iff (RST) WARM_RST && !KEEP_DATA_WE |=>
    KEEP_DATA == $past(KEEP_DATA) && FUNC_DATA == '0 && !IN_WAIT)
    else $error("warm reset scope wrong");
  cold_scope_a: assert property (disable iff (1'b0) RST |-> KEEP_DATA == '0 && FUNC_DATA == '0 && !IN_WAIT)
    else $error("cold reset scope wrong");
  accept_mode_a: assert property ($rose(PM_ACCEPT) |-> $past(PM_REQ) && PM_MODE_NOW == $past(PM_MODE))
    else $error("accepted mode differs");
  off_prep_a: assert property ($rose(PM_ACCEPT) && PM_MODE_NOW == CLPCG_MODE_OFF |->
    $past(IN_WAIT && CACHE_CLEAN_DONE && COHERENCY_OFF_DONE))
    else $error("off accepted unprepared");
  cover property (CLK_TEMP_ON && IN_WAIT);
  cover property (WAKE_PULSE);
  cover property ($rose(PM_ACCEPT) && PM_MODE_NOW == CLPCG_MODE_OFF);
endmodule : clpcg_core_chk
bind clpcg_core clpcg_core_chk #(.KEEP_W(KEEP_W)) i_chk (.*);
`default_nettype wire

//--- clpcg_ppc_model.sv
// partner model: power policy controller with four-phase mode requests
`timescale 1ns/1ps
`default_nettype none
module clpcg_ppc_model
  import clpcg_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PPC_GO,
  input wire logic [CLPCG_MODE_W-1:0] PPC_MODE,
  input wire logic PM_ACCEPT,
  input wire logic CACHE_CLEAN_REQ,
  input wire logic COHERENCY_OFF_REQ,
  output logic PM_REQ,
  output logic [CLPCG_MODE_W-1:0] PM_MODE,
  output logic CACHE_CLEAN_DONE,
  output logic COHERENCY_OFF_DONE,
  output logic PPC_BUSY
);
  logic [1:0] clean_reg;
  logic [1:0] coh_reg;
  // one controller per core domain decides; mode code wobbles while no request stands
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PM_REQ <= 1'b0;
      PM_MODE <= 3'h0;
      PPC_BUSY <= 1'b0;
    end else if (PPC_GO && !PPC_BUSY) begin
      PM_REQ <= 1'b1;
      PM_MODE <= PPC_MODE;
      PPC_BUSY <= 1'b1;
    end else if (PM_REQ && PM_ACCEPT) begin
      PM_REQ <= 1'b0;
    end else if (!PM_REQ) begin
      PM_MODE <= ~PM_MODE;
      PPC_BUSY <= PPC_BUSY && PM_ACCEPT;
    end
  end
  // preparation answers come two cycles late so the core must really wait for them
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clean_reg <= 2'h0;
      coh_reg <= 2'h0;
    end else begin
      clean_reg <= {clean_reg[0], CACHE_CLEAN_REQ};
      coh_reg <= {coh_reg[0], COHERENCY_OFF_REQ};
    end
  end
  assign CACHE_CLEAN_DONE = clean_reg[1];
  assign COHERENCY_OFF_DONE = coh_reg[1];
endmodule : clpcg_ppc_model
`default_nettype wire

//--- clpcg_core_tb.sv
// testbench: directed scenarios for the core low-power clock gating block
`timescale 1ns/1ps
`default_nettype none
module clpcg_core_tb;
  import clpcg_pkg::*;
  logic SYS_CLK = 0, RST = 0, WARM_RST = 0, WAIT_INT_REQ = 0, WAIT_EVT_REQ = 0, SEND_EVENT = 0;
  logic INFLIGHT_BUSY = 0, STORE_PENDING = 0, SERVICE_BUSY = 0, KEEP_DATA_WE = 0, FUNC_DATA_WE = 0, PPC_GO = 0;
  logic [4:0] svc = 0;
  logic [2:0] wk = 0, PPC_MODE = 0;
  logic [7:0] KEEP_DATA_IN = 0, FUNC_DATA_IN = 0;
  logic [2:0] modes [6] = '{CLPCG_MODE_ON, CLPCG_MODE_OFF_EMU, CLPCG_MODE_DBG_RECOV, CLPCG_MODE_WARM_RST,
    CLPCG_MODE_FULL_RET, CLPCG_MODE_OFF};
  wire logic SNOOP_REQ = svc[0], MAINT_REQ = svc[1], UTIL_BUS_REQ = svc[2], INTC_ACCESS_REQ = svc[3];
  wire logic DEBUG_APB_REQ = svc[4], PHYS_IRQ = wk[0], VIRT_IRQ = wk[1], WAKE_EVENT = wk[2];
  wire logic PM_REQ, CACHE_CLEAN_DONE, COHERENCY_OFF_DONE, PPC_BUSY, GATED_CLK, CLK_ENABLE, IN_WAIT;
  wire logic WAIT_IS_EVENT, CLK_TEMP_ON, EVENT_FLAG, WAKE_PULSE, PM_ACCEPT, CACHE_CLEAN_REQ, COHERENCY_OFF_REQ;
  wire logic [2:0] PM_MODE, PM_MODE_NOW;
  wire logic [7:0] KEEP_DATA, FUNC_DATA;
  int num_errors = 0, checked = 0, i, k;
  clpcg_core i_dut (.*);
  clpcg_ppc_model i_ppc (.*);
  initial forever #10 SYS_CLK = ~SYS_CLK;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge SYS_CLK);
  endtask : cyc
  task automatic enter(logic evt);
    cyc(1);
    WAIT_INT_REQ = !evt;
    WAIT_EVT_REQ = evt;
    cyc(1);
    WAIT_INT_REQ = 0;
    WAIT_EVT_REQ = 0;
    for (k = 0; k < 20 && IN_WAIT !== 1'b1; k++) cyc(1);
    chk("in_wait", IN_WAIT, 1);
    chk("wait_kind", WAIT_IS_EVENT, evt);
  endtask : enter
  task automatic wake(int s);
    wk[s] = 1;
    #1 chk("wake_clk", CLK_ENABLE, 1);
    cyc(1);
    wk = 0;
    for (k = 0; k < 3 && WAKE_PULSE !== 1'b1; k++) cyc(1);
    chk("wake_pulse", WAKE_PULSE, 1);
    chk("wait_left", IN_WAIT, 0);
  endtask : wake
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_drain();
    cyc(1);
    INFLIGHT_BUSY = 1;
    STORE_PENDING = 1;
    WAIT_INT_REQ = 1;
    cyc(1);
    WAIT_INT_REQ = 0;
    cyc(4);
    chk("inflight_hold", IN_WAIT, 0);
    INFLIGHT_BUSY = 0;
    cyc(4);
    chk("store_hold", IN_WAIT, 0);
    STORE_PENDING = 0;
    cyc(3);
    chk("gate_off", CLK_ENABLE, 0);
    @(posedge SYS_CLK);
    #1 chk("gated_flat", GATED_CLK, 0);
    cyc(1);
    wake(0);
    for (i = 1; i < 3; i++) begin
      enter(0);
      wake(i);
    end
    $display("drain and wake done");
  endtask : t_drain
  task automatic t_event();
    cyc(1);
    SEND_EVENT = 1;
    cyc(1);
    SEND_EVENT = 0;
    chk("flag_set", EVENT_FLAG, 1);
    WAIT_EVT_REQ = 1;
    cyc(1);
    WAIT_EVT_REQ = 0;
    cyc(3);
    chk("flag_clear", EVENT_FLAG, 0);
    chk("no_entry", IN_WAIT, 0);
    enter(1);
    SEND_EVENT = 1;
    cyc(1);
    SEND_EVENT = 0;
    cyc(2);
    chk("event_wake", IN_WAIT, 0);
    $display("event wait done");
  endtask : t_event
  task automatic t_svc();
    for (i = 0; i < 5; i++) begin
      enter(0);
      svc[i] = 1;
      SERVICE_BUSY = (i == 0);
      #1 chk("svc_clk", CLK_ENABLE, 1);
      cyc(1);
      svc = 0;
      chk("temp_on", CLK_TEMP_ON, 1);
      @(posedge SYS_CLK);
      #1 chk("svc_pulse", GATED_CLK, 1);
      cyc(5);
      chk("busy_keeps", CLK_TEMP_ON, SERVICE_BUSY);
      SERVICE_BUSY = 0;
      cyc(5);
      chk("regated", CLK_TEMP_ON, 0);
      chk("still_wait", IN_WAIT, 1);
      chk("gate_closed", CLK_ENABLE, 0);
      wake(0);
    end
    $display("service reopen done");
  endtask : t_svc
  task automatic t_rst();
    cyc(1);
    KEEP_DATA_IN = 8'h5a;
    FUNC_DATA_IN = 8'ha5;
    KEEP_DATA_WE = 1;
    FUNC_DATA_WE = 1;
    cyc(1);
    KEEP_DATA_WE = 0;
    FUNC_DATA_WE = 0;
    chk("func_wr", FUNC_DATA, 8'ha5);
    enter(0);
    WARM_RST = 1;
    cyc(1);
    WARM_RST = 0;
    chk("keep_warm", KEEP_DATA, 8'h5a);
    chk("func_warm", FUNC_DATA, 8'h00);
    chk("wait_warm", IN_WAIT, 0);
    #3 RST = 1;
    #4 chk("keep_cold", KEEP_DATA, 8'h00);
    cyc(2);
    RST = 0;
    $display("reset scope done");
  endtask : t_rst
  task automatic t_pm();
    for (i = 0; i < 6; i++) begin
      if (i > 3) enter(0);
      PPC_MODE = modes[i];
      PPC_GO = 1;
      cyc(1);
      PPC_GO = 0;
      if (i == 5) begin
        cyc(1);
        chk("clean_req", CACHE_CLEAN_REQ, 1);
        chk("coh_req", COHERENCY_OFF_REQ, 1);
      end
      for (k = 0; k < 40 && PM_ACCEPT !== 1'b1; k++) cyc(1);
      chk("accept", PM_ACCEPT, 1);
      chk("mode_now", PM_MODE_NOW, modes[i]);
      chk("clean_idle", CACHE_CLEAN_REQ, 0);
      chk("coh_idle", COHERENCY_OFF_REQ, 0);
      for (k = 0; k < 10 && PPC_BUSY !== 1'b0; k++) cyc(1);
      chk("released", PM_ACCEPT, 0);
      if (i > 3) wake(0);
    end
    $display("power modes done");
  endtask : t_pm
  initial begin
    #1 RST = 1;
    cyc(6);
    RST = 0;
    t_drain();
    t_event();
    t_svc();
    t_rst();
    t_pm();
    end_sim();
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : clpcg_core_tb
`default_nettype wire
